// File: agu_defs.vh
/*
 * constants for the stack check and program space address unit.
 * assumes a 16-bit data space and a 24-bit program space.
 */
`ifndef AGU_DEFS_VH
`define AGU_DEFS_VH

// ----------------------------------------
// stack lower bound and word step
// ----------------------------------------
`define STK_UNDERFLOW_BOUND 16'h0800
`define STK_WORD_STEP 16'h0002

// ----------------------------------------
// control bit positions
// ----------------------------------------
`define CTL_VIS_ENABLE_BIT 2
`define TBL_CFG_SPACE_BIT 7
`define EA_WINDOW_BIT 15

// ----------------------------------------
// program address source codes
// ----------------------------------------
`define PSRC_NONE 2'h0
`define PSRC_FETCH 2'h1
`define PSRC_TABLE 2'h2
`define PSRC_WINDOW 2'h3

`endif

// File: agu_props.sv
/* assertions on the stack_psv_agu ports.
   bound to the top module, ports matched by name. */
`timescale 1ns/100ps
module agu_props (
	input wire clk_sys, nrst, sp_wr, lim_wr, push_req, push_is_call, data_req, data_wr, table_req, table_wr,
	input wire push_is_exc, fetch_req,
	input wire [7:0] status_low_byte,
	input wire [22:0] pc_fetch,
	input wire stk_wr, stack_error, prog_rd, prog_wr, prog_low_word_only, prog_cfg_space, table_refused,
	input wire [22:0] pc_in,
	input wire [7:0] table_page_register, visibility_page_register,
	input wire [15:0] lim_wdata, data_ea, processor_control_register, stack_pointer_register, stack_limit_register,
	input wire [15:0] stk_addr,
	input wire [31:0] stk_wdata,
	input wire [23:0] prog_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire [15:0] sp = stack_pointer_register;
	// push taken inside both bounds
	sequence s_ok; push_req && !sp_wr && sp >= 16'h0800 && sp <= stack_limit_register; endsequence
	sequence s_wr; stk_wr && !stack_error; endsequence
	property p_push; s_ok |=> s_wr ##0 stk_addr == $past(sp) && sp == stk_addr + 16'h2; endproperty
	a_push: assert property (p_push) else $error("push lost");
	property p_call; s_ok ##0 push_is_call |=> stk_wdata == {9'h0, $past(pc_in)}; endproperty
	a_call: assert property (p_call) else $error("call frame");
	property p_ovf; push_req && !sp_wr && sp > stack_limit_register |=>
		stack_error && !stk_wr && $stable(sp); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow");
	property p_udf; push_req && !sp_wr && sp < 16'h0800 |=> stack_error && !stk_wr; endproperty
	a_udf: assert property (p_udf) else $error("underflow");
	property p_lim; lim_wr |=> stack_limit_register == ($past(lim_wdata) & 16'hfffe); endproperty
	a_lim: assert property (p_lim) else $error("limit");
	property p_tbl; table_req && !table_wr |=> prog_rd && prog_cfg_space == prog_addr[23]
		&& prog_addr == {$past(table_page_register), $past(data_ea)}; endproperty
	a_tbl: assert property (p_tbl) else $error("table");
	property p_tcfg; table_req && table_wr && table_page_register[7] |=> table_refused && !prog_wr; endproperty
	a_tcfg: assert property (p_tcfg) else $error("cfg write");
	property p_win; data_req && !data_wr && !table_req && data_ea[15] && processor_control_register[2] |=> prog_rd
		&& prog_low_word_only && prog_addr == ({1'b0, $past(visibility_page_register), 15'h0} | $past(data_ea) & 16'h7ffe);
	endproperty
	a_win: assert property (p_win) else $error("window");
	property p_exc; s_ok ##0 push_is_exc && !push_is_call |=>
		s_wr ##0 stk_wdata == {$past(status_low_byte), 1'b0, $past(pc_in)}; endproperty
	a_exc: assert property (p_exc) else $error("exc frame");
	property p_fetch; fetch_req && !table_req && !(data_req && data_ea[15] && processor_control_register[2]) |=>
		prog_rd && prog_addr == {1'b0, $past(pc_fetch) & 23'h7ffffe}; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch");
endmodule // agu_props
bind stack_psv_agu agu_props props_u (.*);

// File: stack_limit_check.v
/*
 * stack pointer bounds checker: compares one stack effective address
 * against the limit and the fixed lower bound.
 * assumes the caller qualifies the check with a stack access strobe.
 */
`timescale 1ns/100ps
`include "agu_defs.vh"

module stack_limit_check (
	stk_ea,
	stk_limit,
	is_push,
	overflow,
	underflow
);
	input wire [15:0] stk_ea;
	input wire [15:0] stk_limit;
	input wire is_push;
	output wire overflow;
	output wire underflow;

	// push beyond the limit word traps; equal does not
	assign overflow = is_push && (stk_ea > stk_limit);
	// anything below the bound would reach the register region
	assign underflow = (stk_ea < `STK_UNDERFLOW_BOUND);
endmodule // stack_limit_check

// File: stack_psv_agu.v
/*
 * stack pointer update and checking, pushed program counter framing,
 * and program space address forming for fetch, table and window access.
 * assumes the pipeline gives at most one stack access per clock and
 * that memory buses take the registered address and strobes.
 */
// Overview of operation
// - stack pointer addresses next free word, grows up
// - call push clears pushed counter top bit
// - exception push adds status low byte on top
// - limit register unreset, bit zero forced low
// - every push address checked against limit; pops only against 0800h
// - push at limit passes, next push traps
// - stack address below 0800h traps underflow
// - table address is page over full address
// - page top bit selects configuration space
// - window address is visibility page over 15 bits
// - window ignores bit 15, top bit zero
// - fetch and window address bit zero low
// - table access byte aligned, reads reach configuration
// - window read only, low word only
// - window only when enabled and address top set
// - table writes to configuration space refused
`timescale 1ns/100ps
`include "agu_defs.vh"

module stack_psv_agu (
	clk_sys,
	nrst,
	sp_wr,
	sp_wdata,
	lim_wr,
	lim_wdata,
	push_req,
	pop_req,
	push_is_call,
	push_is_exc,
	pc_in,
	status_low_byte,
	push_data,
	pc_fetch,
	fetch_req,
	data_ea,
	data_req,
	data_wr,
	table_req,
	table_wr,
	table_page_register,
	visibility_page_register,
	processor_control_register,
	stack_pointer_register,
	stack_limit_register,
	stk_addr,
	stk_wr,
	stk_rd,
	stk_wdata,
	stack_error,
	prog_addr,
	prog_rd,
	prog_wr,
	prog_low_word_only,
	prog_cfg_space,
	table_refused,
	window_write_refused,
	data_addr,
	data_rd_out,
	data_wr_out
);
	input wire clk_sys;
	input wire nrst;
	input wire sp_wr;
	input wire [15:0] sp_wdata;
	input wire lim_wr;
	input wire [15:0] lim_wdata;
	input wire push_req;
	input wire pop_req;
	input wire push_is_call;
	input wire push_is_exc;
	input wire [22:0] pc_in;
	input wire [7:0] status_low_byte;
	input wire [15:0] push_data;
	input wire [22:0] pc_fetch;
	input wire fetch_req;
	input wire [15:0] data_ea;
	input wire data_req;
	input wire data_wr;
	input wire table_req;
	input wire table_wr;
	input wire [7:0] table_page_register;
	input wire [7:0] visibility_page_register;
	input wire [15:0] processor_control_register;
	output wire [15:0] stack_pointer_register;
	output wire [15:0] stack_limit_register;
	output reg [15:0] stk_addr;
	output reg stk_wr;
	output reg stk_rd;
	output reg [31:0] stk_wdata;
	output reg stack_error;
	output reg [23:0] prog_addr;
	output reg prog_rd;
	output reg prog_wr;
	output reg prog_low_word_only;
	output reg prog_cfg_space;
	output reg table_refused;
	output reg window_write_refused;
	output reg [15:0] data_addr;
	output reg data_rd_out;
	output reg data_wr_out;

	// ----------------------------------------
	// stack pointer and limit
	// ----------------------------------------
	reg [15:0] sp_r;
	reg [15:0] sp_nxt;
	reg [15:0] lim_r;
	reg [15:0] stk_ea;
	reg [31:0] frame_nxt;
	wire ovf;
	wire unf;
	wire stk_act;
	wire stk_fault;

	assign stack_pointer_register = sp_r;
	assign stack_limit_register = lim_r;
	assign stk_act = push_req | pop_req;

	// push uses current pointer, pop uses pre-decremented one
	always @* begin
		stk_ea = sp_r;
		if (pop_req) begin
			stk_ea = sp_r - `STK_WORD_STEP;
		end
	end

	stack_limit_check u_chk (
		.stk_ea(stk_ea),
		.stk_limit(lim_r),
		.is_push(push_req),
		.overflow(ovf),
		.underflow(unf)
	);

	assign stk_fault = stk_act && (ovf || unf);

	// pushed word framing by push kind
	always @* begin
		frame_nxt = {16'h0000, push_data};
		if (push_is_call) begin
			frame_nxt = {9'h000, pc_in};
		end else if (push_is_exc) begin
			frame_nxt = {status_low_byte, 1'b0, pc_in};
		end
	end

	// pointer update; faulting access leaves it unchanged
	always @* begin
		sp_nxt = sp_r;
		if (sp_wr) begin
			sp_nxt = {sp_wdata[15:1], 1'b0};
		end else if (stk_act && !stk_fault) begin
			if (push_req) begin
				sp_nxt = sp_r + `STK_WORD_STEP;
			end else begin
				sp_nxt = stk_ea;
			end
		end
	end

	// pointer register and stack port
	always @(posedge clk_sys) begin
		if (!nrst) begin
			sp_r <= 16'h0000;
			stk_addr <= 16'h0000;
			stk_wr <= 1'b0;
			stk_rd <= 1'b0;
			stk_wdata <= 32'h00000000;
			stack_error <= 1'b0;
		end else begin
			sp_r <= sp_nxt;
			stk_addr <= stk_ea;
			stk_wr <= push_req && !stk_fault;
			stk_rd <= pop_req && !stk_fault;
			stk_wdata <= frame_nxt;
			stack_error <= stk_fault;
		end
	end

	// limit register has no reset
	always @(posedge clk_sys) begin
		if (lim_wr) begin
			lim_r <= {lim_wdata[15:1], 1'b0};
		end
	end

	// ----------------------------------------
	// program space address forming
	// ----------------------------------------
	reg [1:0] psrc;
	reg [23:0] paddr_nxt;
	wire vis_en;
	wire win_hit;
	wire tbl_cfg;
	wire tbl_bad;

	assign vis_en = processor_control_register[`CTL_VIS_ENABLE_BIT];
	// table ops pause the window
	assign win_hit = data_req && !table_req && vis_en && data_ea[`EA_WINDOW_BIT];
	assign tbl_cfg = table_page_register[`TBL_CFG_SPACE_BIT];
	assign tbl_bad = table_req && table_wr && tbl_cfg;

	// source priority: table, window, fetch
	always @* begin
		psrc = `PSRC_NONE;
		if (table_req) begin
			psrc = `PSRC_TABLE;
		end else if (win_hit) begin
			psrc = `PSRC_WINDOW;
		end else if (fetch_req) begin
			psrc = `PSRC_FETCH;
		end
	end

	// address per source
	always @* begin
		case (psrc)
			`PSRC_TABLE: begin
				paddr_nxt = {table_page_register, data_ea};
			end
			`PSRC_WINDOW: begin
				paddr_nxt = {1'b0, visibility_page_register, data_ea[14:1], 1'b0};
			end
			`PSRC_FETCH: begin
				paddr_nxt = {1'b0, pc_fetch[22:1], 1'b0};
			end
			default: begin
				paddr_nxt = 24'h000000;
			end
		endcase
	end

	// ----------------------------------------
	// program bus strobe decoding
	// ----------------------------------------
	// read strobe per source; window and table writes never read
	function prog_read_of;
		input [1:0] src;
		input tbl_write;
		input win_write;
		begin
			case (src)
				`PSRC_FETCH: begin
					prog_read_of = 1'b1;
				end
				`PSRC_TABLE: begin
					prog_read_of = !tbl_write;
				end
				`PSRC_WINDOW: begin
					prog_read_of = !win_write;
				end
				default: begin
					prog_read_of = 1'b0;
				end
			endcase
		end
	endfunction

	// write strobe: only table writes outside configuration space
	function prog_write_of;
		input [1:0] src;
		input tbl_write;
		input refused;
		begin
			prog_write_of = (src == `PSRC_TABLE) && tbl_write && !refused;
		end
	endfunction

	// program and data bus strobes
	always @(posedge clk_sys) begin
		if (!nrst) begin
			prog_addr <= 24'h000000;
			prog_rd <= 1'b0;
			prog_wr <= 1'b0;
			prog_low_word_only <= 1'b0;
			prog_cfg_space <= 1'b0;
			table_refused <= 1'b0;
			window_write_refused <= 1'b0;
			data_addr <= 16'h0000;
			data_rd_out <= 1'b0;
			data_wr_out <= 1'b0;
		end else begin
			prog_addr <= paddr_nxt;
			prog_rd <= prog_read_of(psrc, table_wr, data_wr);
			prog_wr <= prog_write_of(psrc, table_wr, tbl_bad);
			prog_low_word_only <= (psrc == `PSRC_WINDOW);
			prog_cfg_space <= (psrc == `PSRC_TABLE) && tbl_cfg;
			table_refused <= tbl_bad;
			window_write_refused <= win_hit && data_wr;
			data_addr <= data_ea;
			data_rd_out <= data_req && !win_hit && !data_wr;
			data_wr_out <= data_req && !win_hit && data_wr;
		end
	end
endmodule // stack_psv_agu

// File: stack_ram_model.sv
/* far-side stack memory: keeps the last pushed word.
   fed by the registered stack bus of the design. */
`timescale 1ns/100ps
module stack_ram_model (
	input wire clk_sys,
	input wire stk_wr,
	input wire [31:0] stk_wdata,
	output reg [31:0] top_word
);
	// capture only accepted writes
	always @(posedge clk_sys) begin
		if (stk_wr) begin
			top_word <= stk_wdata;
		end
	end
endmodule // stack_ram_model

// File: tb.sv
/* self-checking bench for stack_psv_agu.
   assumes a 10 MHz clock and sync active-low reset. */
`timescale 1ns/100ps
module tb;
	reg clk_sys = 0, nrst = 0, sp_wr = 0, lim_wr = 0, push_req = 0, pop_req = 0, push_is_call = 0, push_is_exc = 0;
	reg fetch_req = 0, data_req = 0, data_wr = 0, table_req = 0, table_wr = 0;
	reg [15:0] sp_wdata = 0, lim_wdata = 0, push_data = 0, data_ea = 0, processor_control_register = 0;
	reg [22:0] pc_in = 0, pc_fetch = 0;
	reg [7:0] status_low_byte = 0, table_page_register = 0, visibility_page_register = 0;
	wire [15:0] stack_pointer_register, stack_limit_register, stk_addr, data_addr;
	wire [31:0] stk_wdata, top_word;
	wire [23:0] prog_addr;
	wire stk_wr, stk_rd, stack_error, prog_rd, prog_wr, prog_low_word_only, prog_cfg_space, table_refused;
	wire window_write_refused, data_rd_out, data_wr_out;
	integer n_fail = 0, n_checks = 0, cyc = 0;
	localparam [31:0] exc_w = {8'h5a, 1'h0, 23'h7fffff};
	stack_psv_agu dut_u (.*);
	stack_ram_model ram_u (.*);
	always #50 clk_sys = ~clk_sys;
	task at; @(posedge clk_sys); #1; endtask
	// one request cycle, then strobes drop
	task go;
		at;
		{sp_wr, lim_wr, push_req, pop_req, fetch_req, data_req, table_req} = 7'h0;
	endtask
	task chk(input string nm, input [47:0] exp, input [47:0] got);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task close_out;
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 400) begin
			n_fail = n_fail + 1;
			close_out;
		end
	end
	task t_stack;
		at;
		chk("rst", 21'h0, {stack_pointer_register, stk_wr, stk_rd, stack_error, prog_rd, prog_wr});
		{sp_wr, sp_wdata, lim_wr, lim_wdata} = {1'h1, 16'h0800, 1'h1, 16'h0803};
		go;
		chk("lim", 16'h0802, stack_limit_register);
		at;
		{push_req, push_is_call, pc_in} = {2'h3, 23'h7fffff};
		go;
		chk("call", {16'h0800, 32'h007fffff}, {stk_addr, stk_wdata});
		at;
		{push_req, push_is_call, push_is_exc, status_low_byte} = {3'h5, 8'h5a};
		go;
		chk("exc", {2'h1, exc_w}, {stack_error, stk_wr, stk_wdata});
		at;
		{push_req, push_is_exc, push_data} = {2'h2, 16'hbeef};
		go;
		chk("over", {2'h2, 16'h0804}, {stack_error, stk_wr, stack_pointer_register});
		at;
		chk("kept", exc_w, top_word);
		pop_req = 1;
		go;
		chk("pop", {1'h1, 16'h0802, 16'h0802}, {stk_rd, stk_addr, stack_pointer_register});
		at;
		pop_req = 1;
		go;
		at;
		pop_req = 1;
		go;
		chk("under", {2'h2, 16'h0800}, {stack_error, stk_rd, stack_pointer_register});
		at;
		{sp_wr, sp_wdata} = {1'h1, 16'h07fe};
		go;
		at;
		push_req = 1'b1;
		go;
		chk("udfpush", {2'h2, 16'h07fe}, {stack_error, stk_wr, stack_pointer_register});
	endtask
	task t_prog;
		at;
		{table_req, table_page_register, data_ea} = {1'h1, 8'h85, 16'h1235};
		go;
		chk("program_word_read_op", 26'h3851235, {prog_rd, prog_cfg_space, prog_addr});
		at;
		{table_req, table_wr} = 2'h3;
		go;
		chk("tblwr", 2'h1, {prog_wr, table_refused});
		at;
		{table_req, table_page_register} = {1'h1, 8'h05};
		go;
		chk("tblwu", {2'h2, 24'h051235}, {prog_wr, table_refused, prog_addr});
		at;
		{table_wr, data_req, data_ea} = {2'h1, 16'h9235};
		{processor_control_register, visibility_page_register} = {16'h0004, 8'h3a};
		go;
		chk("winrd", 26'h31d1234, {prog_rd, prog_low_word_only, prog_addr});
		at;
		{data_req, data_wr} = 2'h3;
		go;
		chk("winwr", 3'h1, {prog_rd, prog_wr, window_write_refused});
		at;
		{fetch_req, pc_fetch} = {1'h1, 23'h012345};
		go;
		chk("fetch", 25'h1012344, {prog_rd, prog_addr});
	endtask
	task t_data;
		at;
		{processor_control_register, data_req, data_wr, data_ea} = {16'h0000, 2'h2, 16'h9235};
		go;
		chk("datard", {3'h4, 16'h9235}, {data_rd_out, data_wr_out, prog_rd, data_addr});
		at;
		{processor_control_register, data_req, data_wr, data_ea} = {16'h0004, 2'h3, 16'h0246};
		go;
		chk("datawr", {3'h2, 16'h0246}, {data_rd_out, data_wr_out, window_write_refused, data_addr});
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		#1;
		nrst = 1;
		t_stack;
		t_prog;
		t_data;
		close_out;
	end
endmodule // tb
